// ---- design/ref_ctl_pkg.sv ----
package ref_ctl_pkg;

	// ------------------------------------------------------------
	// bus geometry
	// ------------------------------------------------------------
	localparam int ADDR_W = 16;
	localparam int DATA_W = 32;
	localparam int NREF   = 8;
	localparam int NEVT   = 4;
	localparam int NIRQ   = NREF * NEVT;
	localparam int STEP_W = 16;

	// ------------------------------------------------------------
	// register indices (byte address is four times the index)
	// ------------------------------------------------------------
	localparam logic [11:0] IDX_IRQ_CLR_AB   = 12'hA08;
	localparam logic [11:0] IDX_IRQ_CLR_B    = 12'hA09;
	localparam logic [11:0] IDX_IRQ_CLR_C    = 12'hA0A;
	localparam logic [11:0] IDX_IRQ_CLR_D    = 12'hA0B;
	localparam logic [11:0] IDX_PHASE_CTRL   = 12'hA0C;
	localparam logic [11:0] IDX_PROFILE      = 12'hA0D;
	localparam logic [11:0] IDX_TIMEOUT      = 12'hA0E;
	localparam logic [11:0] IDX_OVERRIDE     = 12'hA0F;
	localparam logic [11:0] IDX_BYPASS       = 12'hA10;
	localparam logic [11:0] IDX_STEP_LO      = 12'h314;
	localparam logic [11:0] IDX_STEP_HI      = 12'h315;
	localparam logic [11:0] IDX_IRQ_STATUS   = 12'hA20;
	localparam logic [11:0] IDX_IRQ_MASK     = 12'hA21;
	localparam logic [11:0] IDX_PHASE_OFFSET = 12'hA22;

	localparam logic [15:0] A_IRQ_CLR_AB   = {2'b00, IDX_IRQ_CLR_AB, 2'b00};
	localparam logic [15:0] A_IRQ_CLR_B    = {2'b00, IDX_IRQ_CLR_B, 2'b00};
	localparam logic [15:0] A_IRQ_CLR_C    = {2'b00, IDX_IRQ_CLR_C, 2'b00};
	localparam logic [15:0] A_IRQ_CLR_D    = {2'b00, IDX_IRQ_CLR_D, 2'b00};
	localparam logic [15:0] A_PHASE_CTRL   = {2'b00, IDX_PHASE_CTRL, 2'b00};
	localparam logic [15:0] A_PROFILE      = {2'b00, IDX_PROFILE, 2'b00};
	localparam logic [15:0] A_TIMEOUT      = {2'b00, IDX_TIMEOUT, 2'b00};
	localparam logic [15:0] A_OVERRIDE     = {2'b00, IDX_OVERRIDE, 2'b00};
	localparam logic [15:0] A_BYPASS       = {2'b00, IDX_BYPASS, 2'b00};
	localparam logic [15:0] A_STEP_LO      = {2'b00, IDX_STEP_LO, 2'b00};
	localparam logic [15:0] A_STEP_HI      = {2'b00, IDX_STEP_HI, 2'b00};
	localparam logic [15:0] A_IRQ_STATUS   = {2'b00, IDX_IRQ_STATUS, 2'b00};
	localparam logic [15:0] A_IRQ_MASK     = {2'b00, IDX_IRQ_MASK, 2'b00};
	localparam logic [15:0] A_PHASE_OFFSET = {2'b00, IDX_PHASE_OFFSET, 2'b00};

	// ------------------------------------------------------------
	// fields and reset values
	// ------------------------------------------------------------
	localparam int PH_INCR_BIT  = 0;
	localparam int PH_DECR_BIT  = 1;
	localparam int PH_RESET_BIT = 2;

	localparam logic [7:0]  RST_OVERRIDE = 8'h00;
	localparam logic [7:0]  RST_BYPASS   = 8'h00;
	localparam logic [15:0] RST_STEP     = 16'h0000;
	localparam logic [31:0] RST_IRQ_MASK = 32'h0000_0000;

endpackage

// ---- design/ref_ctl_strobes.sv ----
`timescale 1ns/1ps

module ref_ctl_strobes
	import ref_ctl_pkg::*;
#(
	parameter int OFFSET_W = 32
)
(
	input  wire logic                          pclk,
	input  wire logic                          presetn,
	input  wire logic                          psel,
	input  wire logic                          penable,
	input  wire logic                          pwrite,
	input  wire logic [ref_ctl_pkg::ADDR_W-1:0] paddr,
	input  wire logic [ref_ctl_pkg::DATA_W-1:0] pwdata,
	output logic      [ref_ctl_pkg::DATA_W-1:0] prdata,
	output logic                               pready,
	output logic                               pslverr,
	input  wire logic [ref_ctl_pkg::NIRQ-1:0]   ref_event,
	input  wire logic                          clear_all,
	output logic                               irq,
	output logic      [OFFSET_W-1:0]           phase_offset,
	output logic      [ref_ctl_pkg::NREF-1:0]   profile_start,
	output logic      [ref_ctl_pkg::NREF-1:0]   timeout_force,
	output logic      [ref_ctl_pkg::NREF-1:0]   mon_override,
	output logic      [ref_ctl_pkg::NREF-1:0]   mon_bypass
);

	import ref_ctl_pkg::*;

	// ------------------------------------------------------------
	// elaboration checks
	// ------------------------------------------------------------
	if (OFFSET_W < STEP_W || OFFSET_W > DATA_W)
	begin : g_bad_width
		$error("OFFSET_W must lie between step width and bus width");
	end

	// ------------------------------------------------------------
	// state
	// ------------------------------------------------------------
	logic [NIRQ-1:0]   irq_status_q;
	logic [NIRQ-1:0]   irq_mask_q;
	logic [STEP_W-1:0] step_q;
	logic [NIRQ-1:0]   clr_vec;
	logic [DATA_W-1:0] rd_data;
	logic              rd_hit;
	logic              access;
	logic              wr_en;
	logic [7:0]        wbyte;

	// ------------------------------------------------------------
	// apb handshake: one wait cycle, then pready
	// ------------------------------------------------------------
	assign access = psel && penable;
	assign wr_en  = access && pready && pwrite;
	assign wbyte  = pwdata[7:0];

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			pready <= 1'b0;
		else
			pready <= access && !pready;
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			prdata  <= '0;
			pslverr <= 1'b0;
		end
		else if (access && !pready)
		begin
			prdata  <= pwrite ? '0 : rd_data;
			pslverr <= !rd_hit;
		end
		else
		begin
			prdata  <= '0;
			pslverr <= 1'b0;
		end
	end

	// ------------------------------------------------------------
	// address decode, read data (strobe registers read as zero)
	// ------------------------------------------------------------
	always_comb
	begin
		rd_data = '0;
		rd_hit  = 1'b1;
		if (paddr == A_IRQ_CLR_AB || paddr == A_IRQ_CLR_B ||
			paddr == A_IRQ_CLR_C || paddr == A_IRQ_CLR_D)
			rd_data = '0;
		else if (paddr == A_PHASE_CTRL || paddr == A_PROFILE ||
			paddr == A_TIMEOUT)
			rd_data = '0;
		else if (paddr == A_OVERRIDE)
			rd_data = {24'h00_0000, mon_override};
		else if (paddr == A_BYPASS)
			rd_data = {24'h00_0000, mon_bypass};
		else if (paddr == A_STEP_LO)
			rd_data = {24'h00_0000, step_q[7:0]};
		else if (paddr == A_STEP_HI)
			rd_data = {24'h00_0000, step_q[15:8]};
		else if (paddr == A_IRQ_STATUS)
			rd_data = irq_status_q;
		else if (paddr == A_IRQ_MASK)
			rd_data = irq_mask_q;
		else if (paddr == A_PHASE_OFFSET)
			rd_data = DATA_W'(phase_offset);
		else
			rd_hit = 1'b0;
	end

	// ------------------------------------------------------------
	// interrupt clear strobes, one byte per reference pair
	// ------------------------------------------------------------
	always_comb
	begin
		clr_vec = '0;
		if (wr_en && paddr == A_IRQ_CLR_AB)
			clr_vec[7:0] = wbyte;
		else if (wr_en && paddr == A_IRQ_CLR_B)
			clr_vec[15:8] = wbyte;
		else if (wr_en && paddr == A_IRQ_CLR_C)
			clr_vec[23:16] = wbyte;
		else if (wr_en && paddr == A_IRQ_CLR_D)
			clr_vec[31:24] = wbyte;
	end

	// ------------------------------------------------------------
	// latched interrupts, mask, interrupt output
	// ------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			irq_mask_q <= RST_IRQ_MASK;
		else if (wr_en && paddr == A_IRQ_MASK)
			irq_mask_q <= pwdata;
	end

	// new event wins over a clear in the same cycle
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			irq_status_q <= '0;
		else
			irq_status_q <= ((clear_all ? '0 : irq_status_q & ~clr_vec))
				| (ref_event & ~irq_mask_q);
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			irq <= 1'b0;
		else
			irq <= |(irq_status_q & ~irq_mask_q);
	end

	// ------------------------------------------------------------
	// incremental phase offset
	// ------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			step_q <= RST_STEP;
		else if (wr_en && paddr == A_STEP_LO)
			step_q[7:0] <= wbyte;
		else if (wr_en && paddr == A_STEP_HI)
			step_q[15:8] <= wbyte;
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			phase_offset <= '0;
		else if (wr_en && paddr == A_PHASE_CTRL)
		begin
			if (wbyte[PH_RESET_BIT])
				phase_offset <= '0;
			else if (wbyte[PH_INCR_BIT] && !wbyte[PH_DECR_BIT])
				phase_offset <= phase_offset
					+ OFFSET_W'(step_q);
			else if (wbyte[PH_DECR_BIT] && !wbyte[PH_INCR_BIT])
				phase_offset <= phase_offset
					- OFFSET_W'(step_q);
		end
	end

	// ------------------------------------------------------------
	// one-cycle start and timeout strobes
	// ------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			profile_start <= '0;
		else if (wr_en && paddr == A_PROFILE)
			profile_start <= wbyte;
		else
			profile_start <= '0;
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			timeout_force <= '0;
		else if (wr_en && paddr == A_TIMEOUT)
			timeout_force <= wbyte;
		else
			timeout_force <= '0;
	end

	// ------------------------------------------------------------
	// static monitor controls
	// ------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			mon_override <= RST_OVERRIDE;
		else if (wr_en && paddr == A_OVERRIDE)
			mon_override <= wbyte;
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			mon_bypass <= RST_BYPASS;
		else if (wr_en && paddr == A_BYPASS)
			mon_bypass <= wbyte;
	end

	// ------------------------------------------------------------
	// assertions
	// ------------------------------------------------------------
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	a_clear_pair_map: assert property (
		wr_en && paddr == A_IRQ_CLR_D && wbyte[7] && !ref_event[31]
		&& !clear_all |=> !irq_status_q[31])
		else $error("pair clear bit 7 of last byte missed ref DD");

	a_clear_byte_order: assert property (
		wr_en && paddr == A_IRQ_CLR_B && irq_status_q[0]
		&& !clear_all |=> irq_status_q[0])
		else $error("second clear byte disturbed first pair");

	a_clear_resets_bit: assert property (
		wr_en && paddr == A_IRQ_CLR_AB && wbyte[0] && !ref_event[0]
		|=> !irq_status_q[0])
		else $error("clear strobe left interrupt bit set");

	a_latch_only_cleared: assert property (
		!clear_all |=> ((~irq_status_q & $past(irq_status_q)
		& ~$past(clr_vec)) == '0))
		else $error("interrupt bit dropped without a clear");

	a_masked_no_latch: assert property (
		ref_event[5] && irq_mask_q[5] && !irq_status_q[5]
		&& !(wr_en && paddr == A_IRQ_MASK) |=> !irq_status_q[5])
		else $error("masked event latched");

	a_event_beats_clear: assert property (
		ref_event[9] && !irq_mask_q[9] && !(wr_en && paddr == A_IRQ_MASK)
		|=> irq_status_q[9] ##1 irq)
		else $error("unmasked event lost or no interrupt");

	a_offset_reset: assert property (
		wr_en && paddr == A_PHASE_CTRL && wbyte[PH_RESET_BIT]
		|=> phase_offset == '0)
		else $error("phase offset not cleared");

	a_offset_incr: assert property (
		wr_en && paddr == A_PHASE_CTRL && wbyte[2:0] == 3'b001
		|=> phase_offset == $past(phase_offset) + OFFSET_W'($past(step_q))
		##1 $stable(phase_offset) [*2])
		else $error("increment not applied exactly once");

	a_offset_decr: assert property (
		wr_en && paddr == A_PHASE_CTRL && wbyte[2:0] == 3'b010
		|=> phase_offset == $past(phase_offset) - OFFSET_W'($past(step_q)))
		else $error("decrement not applied");

	a_reset_wins: assert property (
		wr_en && paddr == A_PHASE_CTRL && wbyte[2:0] == 3'b101
		|=> phase_offset == '0)
		else $error("reset lost to increment");

	a_profile_pulse: assert property (
		wr_en && paddr == A_PROFILE |=> profile_start == $past(wbyte))
		else $error("profile start does not follow write");

	a_profile_selfclr: assert property (
		profile_start != '0 |=> profile_start == '0)
		else $error("profile start held beyond one cycle");

	a_timeout_pulse: assert property (
		wr_en && paddr == A_TIMEOUT |=> timeout_force == $past(wbyte)
		##1 timeout_force == '0)
		else $error("forced timeout not a single pulse");

	a_override_static: assert property (
		!(wr_en && paddr == A_OVERRIDE) |=> $stable(mon_override))
		else $error("override changed without a write");

	a_bypass_write: assert property (
		wr_en && paddr == A_BYPASS |=> mon_bypass == $past(wbyte))
		else $error("bypass did not take written value");

	a_bypass_static: assert property (
		!(wr_en && paddr == A_BYPASS) |=> $stable(mon_bypass))
		else $error("bypass changed without a write");

	a_override_write: assert property (
		wr_en && paddr == A_OVERRIDE |=> mon_override == $past(wbyte))
		else $error("override did not take written value");

	a_profile_idle: assert property (
		!(wr_en && paddr == A_PROFILE) |=> profile_start == '0)
		else $error("profile start without a write");

	a_timeout_idle: assert property (
		!(wr_en && paddr == A_TIMEOUT) |=> timeout_force == '0)
		else $error("forced timeout without a write");

	c_incr_seen: cover property (
		wr_en && paddr == A_PHASE_CTRL && wbyte[PH_INCR_BIT]);
	c_profile_seen: cover property (profile_start[7]);
	c_irq_cleared: cover property (irq ##[1:20] !irq);
	c_clear_all_seen: cover property (clear_all && irq_status_q != '0);

endmodule // ref_ctl_strobes

// ---- testbench/ref_input_control_strobes_tb_top.sv ----
`timescale 1ns/1ps
`define CHK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin \
	error_cnt++; $display("CHECK FAILED %s exp %h got %h", nm, e, g); end end

module ref_input_control_strobes_tb_top;
	import ref_ctl_pkg::*;

	logic        pclk          = 1'b0;
	logic        presetn       = 1'b0;
	logic        psel          = 1'b0;
	logic        penable       = 1'b0;
	logic        pwrite        = 1'b0;
	logic [15:0] paddr         = 16'h0000;
	logic [31:0] pwdata        = 32'h0000_0000;
	logic [31:0] ref_event     = 32'h0000_0000;
	logic        clear_all     = 1'b0;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic        irq;
	logic [31:0] phase_offset;
	logic [7:0]  profile_start;
	logic [7:0]  timeout_force;
	logic [7:0]  mon_override;
	logic [7:0]  mon_bypass;
	logic [33:0] exp_q [$];
	logic [33:0] ent;
	logic [31:0] seed          = 32'h17E076F7;
	logic [31:0] v;
	logic [31:0] off;
	logic [15:0] step;
	logic [15:0] clr_a [4]     = '{A_IRQ_CLR_AB, A_IRQ_CLR_B,
		A_IRQ_CLR_C, A_IRQ_CLR_D};
	logic [2:0]  ops [10]      = '{1, 1, 2, 2, 2, 3, 5, 1, 6, 4};
	int          error_cnt     = 0;
	int          checks_done   = 0;
	int          cycles        = 0;

	ref_ctl_strobes #(.OFFSET_W(32)) dut (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .ref_event(ref_event),
		.clear_all(clear_all), .irq(irq), .phase_offset(phase_offset),
		.profile_start(profile_start), .timeout_force(timeout_force),
		.mon_override(mon_override), .mon_bypass(mon_bypass)
	);

	always #5 pclk = ~pclk;

	task automatic complete_run();
		$display("checks %0d errors %0d", checks_done, error_cnt);
		if (error_cnt == 0 && checks_done > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	always @(posedge pclk)
	begin
		cycles++;
		if (cycles == 50000)
		begin
			error_cnt++;
			complete_run();
		end
	end

	// ------------------------------------------------------------
	// apb master, expectation noted per transfer
	// ------------------------------------------------------------
	task automatic apb(input logic w, input logic [15:0] a,
		input logic [31:0] d, input logic [31:0] e, input logic err);
		int waits = 0;
		exp_q.push_back({w, err, e});
		@(posedge pclk);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(negedge pclk);
		while (pready !== 1'b1)
		begin
			waits++;
			@(negedge pclk);
		end
		`CHK("pready_wait", 1, waits)
		@(posedge pclk);
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic wr(input logic [15:0] a, input logic [31:0] d);
		apb(1'b1, a, d, 32'h0, 1'b0);
	endtask

	task automatic rd(input logic [15:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0, e, 1'b0);
	endtask

	// results taken when the slave answers
	always @(negedge pclk)
		if (psel && penable && pready === 1'b1)
		begin
			ent = exp_q.pop_front();
			`CHK("pslverr", ent[32], pslverr)
			if (!ent[33])
				`CHK("prdata", ent[31:0], prdata)
		end

	task automatic pulse_chk(input logic [15:0] a, input logic [7:0] p);
		wr(a, {24'h0, p});
		@(negedge pclk);
		`CHK("profile_start", (a == A_PROFILE) ? p : 8'h0, profile_start)
		`CHK("timeout_force", (a == A_TIMEOUT) ? p : 8'h0, timeout_force)
		@(negedge pclk);
		`CHK("strobe_idle", 16'h0, {profile_start, timeout_force})
	endtask

	task automatic ev(input logic [31:0] e);
		@(posedge pclk);
		ref_event <= e;
		@(posedge pclk);
		ref_event <= 32'h0;
		repeat (2) @(negedge pclk);
	endtask

	// ------------------------------------------------------------
	// main sequence
	// ------------------------------------------------------------
	initial
	begin
		repeat (12) @(posedge pclk);
		presetn <= 1'b1;
		rd(A_OVERRIDE, {24'h0, RST_OVERRIDE});
		rd(A_BYPASS, {24'h0, RST_BYPASS});
		rd(A_IRQ_MASK, RST_IRQ_MASK);
		rd(A_PHASE_OFFSET, 32'h0);
		v = $random(seed);
		wr(A_OVERRIDE, {24'h0, v[7:0]});
		wr(A_BYPASS, {24'h0, ~v[7:0]});
		@(negedge pclk);
		`CHK("mon_override", v[7:0], mon_override)
		`CHK("mon_bypass", ~v[7:0], mon_bypass)
		rd(A_BYPASS, {24'h0, ~v[7:0]});
		for (int b = 0; b < 8; b++)
		begin
			pulse_chk(A_PROFILE, 8'h1 << b);
			pulse_chk(A_TIMEOUT, 8'h1 << b);
		end
		v = $random(seed);
		pulse_chk(A_PROFILE, v[7:0]);
		pulse_chk(A_TIMEOUT, v[15:8]);
		rd(A_PROFILE, 32'h0);
		apb(1'b0, 16'h0100, 32'h0, 32'h0, 1'b1);
		apb(1'b1, 16'h0100, 32'hFF, 32'h0, 1'b1);
		step = 16'($random(seed));
		off  = 32'h0;
		wr(A_STEP_LO, {24'h0, step[7:0]});
		wr(A_STEP_HI, {24'h0, step[15:8]});
		for (int i = 0; i < 10; i++)
		begin
			wr(A_PHASE_CTRL, {29'h0, ops[i]});
			if (ops[i][2])
				off = 32'h0;
			else if (ops[i] == 3'd1)
				off = off + {16'h0, step};
			else if (ops[i] == 3'd2)
				off = off - {16'h0, step};
			@(negedge pclk);
			`CHK("phase_offset", off, phase_offset)
			rd(A_PHASE_OFFSET, off);
		end
		for (int b = 0; b < 32; b++)
		begin
			ev(32'h1 << b);
			`CHK("irq_set", 1'b1, irq)
			wr(clr_a[b / 8], {24'h0, ~(8'h1 << (b % 8))});
			rd(A_IRQ_STATUS, 32'h1 << b);
			wr(clr_a[b / 8], {24'h0, 8'h1 << (b % 8)});
			rd(A_IRQ_STATUS, 32'h0);
			`CHK("irq_clear", 1'b0, irq)
		end
		wr(A_IRQ_MASK, 32'hFFFF_FFFF);
		rd(A_IRQ_MASK, 32'hFFFF_FFFF);
		v = $random(seed) | 32'h1;
		ev(v);
		rd(A_IRQ_STATUS, 32'h0);
		`CHK("irq_masked", 1'b0, irq)
		wr(A_IRQ_MASK, 32'h0);
		ev(v);
		rd(A_IRQ_STATUS, v);
		wr(A_IRQ_CLR_B, 32'h0000_00FF);
		rd(A_IRQ_STATUS, v & 32'hFFFF_00FF);
		@(posedge pclk);
		clear_all <= 1'b1;
		@(posedge pclk);
		clear_all <= 1'b0;
		rd(A_IRQ_STATUS, 32'h0);
		`CHK("irq_all", 1'b0, irq)
		repeat (3) @(posedge pclk);
		complete_run();
	end
endmodule // ref_input_control_strobes_tb_top
